// File: rtl/sld_pkg.sv
package sld_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_DBG_CFG    = 10'h011;
  localparam logic [9:0] IDX_DBG_SRC    = 10'h01F;
  localparam logic [9:0] IDX_EXT_STATUS = 10'h020;
  localparam logic [9:0] IDX_PROC_STAT  = 10'h040;
  localparam logic [9:0] IDX_LINK_SETUP = 10'h080;
  localparam logic [9:0] IDX_STATIC_FWD = 10'h0A0;
  localparam int         LINK_SEL_W     = 3;

  // Debug pin configuration and debug source fields
  localparam int DBG_REQ_EN_BIT   = 1;
  localparam int DBG_DRIVE_EN_BIT = 0;
  localparam int SRC_PIN_BIT      = 4;
  localparam int SRC_CORE1_BIT    = 1;
  localparam int SRC_CORE0_BIT    = 0;

  // Link status fields
  localparam int ST_KIND_HI  = 25;
  localparam int ST_KIND_LO  = 24;
  localparam int ST_DEST_HI  = 23;
  localparam int ST_DEST_LO  = 16;
  localparam int ST_DIR_HI   = 11;
  localparam int ST_DIR_LO   = 8;
  localparam int ST_NET_HI   = 5;
  localparam int ST_NET_LO   = 4;
  localparam int ST_JUNK_BIT = 2;
  localparam int ST_DST_BIT  = 1;
  localparam int ST_SRC_BIT  = 0;

  // Link setup fields
  localparam int CFG_EN_BIT     = 31;
  localparam int CFG_WIDE_BIT   = 30;
  localparam int CFG_ERR_BIT    = 27;
  localparam int CFG_GIVEN_BIT  = 26;
  localparam int CFG_HELD_BIT   = 25;
  localparam int CFG_CREDIT_REQUEST_TOKEN_BIT  = 24;
  localparam int CFG_RXRST_BIT  = 23;
  localparam int CFG_SYM_HI     = 21;
  localparam int CFG_SYM_LO     = 11;
  localparam int CFG_TOK_HI     = 10;
  localparam int CFG_TOK_LO     = 0;

  // Static forwarding fields
  localparam int FWD_EN_BIT   = 31;
  localparam int FWD_PROC_BIT = 8;
  localparam int FWD_CHAN_HI  = 4;
  localparam int FWD_CHAN_LO  = 0;

  // Static register slot to link letter (A=0 .. H=7): C D A B G H E F
  localparam logic [23:0] FWD_SLOT_MAP = {3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h2};

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    SLD_G_NONE   = 3'h0,
    SLD_G_DBGCFG = 3'h1,
    SLD_G_DBGSRC = 3'h3,
    SLD_G_EXT    = 3'h2,
    SLD_G_PROC   = 3'h6,
    SLD_G_SETUP  = 3'h7,
    SLD_G_FWD    = 3'h5
  } sld_group_e;

endpackage

// File: rtl/sld_regs.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module sld_regs #(
  parameter int NUM_LINKS = 8,
  parameter int NUM_PLINKS = 8
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,

  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,

  // Write protection
  input  wire logic                         config_write_lock,

  // Debug line and cores
  input  wire logic                         shared_debug_line_n_in,
  output logic                              shared_debug_line_n_out,
  output logic                              shared_debug_line_n_oe,
  input  wire logic                         core1_in_debug_flag,
  input  wire logic                         core0_drives_debug_line,
  output logic                              core1_debug_request,

  // External link status
  input  wire logic [NUM_LINKS-1:0][1:0]    ext_source_target_kind,
  input  wire logic [NUM_LINKS-1:0][7:0]    ext_dest_link,
  input  wire logic [NUM_LINKS-1:0]         ext_junk,
  input  wire logic [NUM_LINKS-1:0]         ext_dest_busy,
  input  wire logic [NUM_LINKS-1:0]         ext_source_busy,

  // Processor link status
  input  wire logic [NUM_PLINKS-1:0][1:0]   proc_source_target_kind,
  input  wire logic [NUM_PLINKS-1:0][7:0]   proc_dest_link,
  input  wire logic [NUM_PLINKS-1:0]        proc_junk,
  input  wire logic [NUM_PLINKS-1:0]        proc_dest_busy,
  input  wire logic [NUM_PLINKS-1:0]        proc_source_busy,

  // Receiver and credit
  input  wire logic [NUM_LINKS-1:0]         link_rx_error,
  input  wire logic [NUM_LINKS-1:0]         link_credit_issued,
  input  wire logic [NUM_LINKS-1:0]         link_credit_held,

  // Routing assignment
  output logic      [NUM_LINKS-1:0][3:0]    link_direction,
  output logic      [NUM_LINKS-1:0][1:0]    link_network,
  output logic      [NUM_PLINKS-1:0][1:0]   proc_link_network,

  // Link setup
  output logic      [NUM_LINKS-1:0]         link_enable,
  output logic      [NUM_LINKS-1:0]         link_five_wire,
  output logic      [NUM_LINKS-1:0]         link_credit_request_token,
  output logic      [NUM_LINKS-1:0]         link_rx_reset,
  output logic      [NUM_LINKS-1:0][11:0]   link_symbol_gap,
  output logic      [NUM_LINKS-1:0][11:0]   link_token_gap,

  // Static forwarding
  output logic      [NUM_LINKS-1:0]         fwd_enable,
  output logic      [NUM_LINKS-1:0]         fwd_processor,
  output logic      [NUM_LINKS-1:0][4:0]    fwd_channel_end
);

  // Map a word index onto a register group
  // Short ranges fall to unmapped
  function automatic sld_pkg::sld_group_e group_of(input logic [9:0] idx);
    logic [9:0] base;
    base = {idx[9:3], 3'h0};
    if (idx == sld_pkg::IDX_DBG_CFG) begin
      group_of = sld_pkg::SLD_G_DBGCFG;
    end else if (idx == sld_pkg::IDX_DBG_SRC) begin
      group_of = sld_pkg::SLD_G_DBGSRC;
    end else if (base == sld_pkg::IDX_EXT_STATUS && int'(idx[2:0]) < NUM_LINKS) begin
      group_of = sld_pkg::SLD_G_EXT;
    end else if (base == sld_pkg::IDX_PROC_STAT && int'(idx[2:0]) < NUM_PLINKS) begin
      group_of = sld_pkg::SLD_G_PROC;
    end else if (base == sld_pkg::IDX_LINK_SETUP && int'(idx[2:0]) < NUM_LINKS) begin
      group_of = sld_pkg::SLD_G_SETUP;
    end else if (base == sld_pkg::IDX_STATIC_FWD && int'(idx[2:0]) < NUM_LINKS) begin
      group_of = sld_pkg::SLD_G_FWD;
    end else begin
      group_of = sld_pkg::SLD_G_NONE;
    end
  endfunction

  // Static register slot to link number
  // Reads and writes share one map
  function automatic logic [2:0] fwd_link_of(input logic [2:0] slot);
    fwd_link_of = sld_pkg::FWD_SLOT_MAP[slot*3 +: 3];
  endfunction

  // Bus decode
  logic [9:0]               word_idx;
  logic [2:0]               slot;
  sld_pkg::sld_group_e      grp;
  logic                     setup_ph;
  logic                     wr_take;
  logic                     wr_ok;
  logic [31:0]              rd_word;

  // Debug state
  logic [1:0]               dbg_cfg_q;
  logic [2:0]               dbg_src_q;
  logic                     line_meta_q;
  logic                     line_sync_q;
  logic                     line_prev_q;
  logic                     line_fall;
  // Link state
  logic [NUM_LINKS-1:0]     err_q;
  logic [NUM_LINKS-1:0][10:0] sym_field_q;
  logic [NUM_LINKS-1:0][10:0] tok_field_q;

  // Word index from byte address
  assign word_idx = paddr[11:2];
  assign slot     = paddr[2 +: sld_pkg::LINK_SEL_W];
  assign grp      = group_of(word_idx);
  assign setup_ph = psel & ~penable;
  assign wr_take  = psel & penable & pready & pwrite;
  // Locked writes are refused whole, mapped or not
  assign wr_ok    = wr_take & (grp != sld_pkg::SLD_G_NONE) & ~config_write_lock;

  // Read mux; unlisted bits stay zero
  always_comb begin
    rd_word = sld_pkg::ZERO_WORD;
    unique case (grp)
      sld_pkg::SLD_G_DBGCFG: begin
        rd_word[sld_pkg::DBG_REQ_EN_BIT]   = dbg_cfg_q[1];
        rd_word[sld_pkg::DBG_DRIVE_EN_BIT] = dbg_cfg_q[0];
      end

      sld_pkg::SLD_G_DBGSRC: begin
        rd_word[sld_pkg::SRC_PIN_BIT]   = dbg_src_q[2];
        rd_word[sld_pkg::SRC_CORE1_BIT] = dbg_src_q[1];
        rd_word[sld_pkg::SRC_CORE0_BIT] = dbg_src_q[0];
      end

      sld_pkg::SLD_G_EXT: begin
        rd_word[sld_pkg::ST_KIND_HI:sld_pkg::ST_KIND_LO] = ext_source_target_kind[slot];
        rd_word[sld_pkg::ST_DEST_HI:sld_pkg::ST_DEST_LO] = ext_dest_link[slot];
        rd_word[sld_pkg::ST_DIR_HI:sld_pkg::ST_DIR_LO]   = link_direction[slot];
        rd_word[sld_pkg::ST_NET_HI:sld_pkg::ST_NET_LO]   = link_network[slot];
        rd_word[sld_pkg::ST_JUNK_BIT] = ext_junk[slot];
        rd_word[sld_pkg::ST_DST_BIT]  = ext_dest_busy[slot];
        rd_word[sld_pkg::ST_SRC_BIT]  = ext_source_busy[slot];
      end

      // No direction field
      sld_pkg::SLD_G_PROC: begin
        rd_word[sld_pkg::ST_KIND_HI:sld_pkg::ST_KIND_LO] = proc_source_target_kind[slot];
        rd_word[sld_pkg::ST_DEST_HI:sld_pkg::ST_DEST_LO] = proc_dest_link[slot];
        rd_word[sld_pkg::ST_NET_HI:sld_pkg::ST_NET_LO]   = proc_link_network[slot];
        rd_word[sld_pkg::ST_JUNK_BIT] = proc_junk[slot];
        rd_word[sld_pkg::ST_DST_BIT]  = proc_dest_busy[slot];
        rd_word[sld_pkg::ST_SRC_BIT]  = proc_source_busy[slot];
      end

      // Bits 24 and 23 read zero
      sld_pkg::SLD_G_SETUP: begin
        rd_word[sld_pkg::CFG_EN_BIT]    = link_enable[slot];
        rd_word[sld_pkg::CFG_WIDE_BIT]  = link_five_wire[slot];
        rd_word[sld_pkg::CFG_ERR_BIT]   = err_q[slot];
        rd_word[sld_pkg::CFG_GIVEN_BIT] = link_credit_issued[slot];
        rd_word[sld_pkg::CFG_HELD_BIT]  = link_credit_held[slot];
        rd_word[sld_pkg::CFG_SYM_HI:sld_pkg::CFG_SYM_LO] = sym_field_q[slot];
        rd_word[sld_pkg::CFG_TOK_HI:sld_pkg::CFG_TOK_LO] = tok_field_q[slot];
      end

      sld_pkg::SLD_G_FWD: begin
        rd_word[sld_pkg::FWD_EN_BIT]   = fwd_enable[fwd_link_of(slot)];
        rd_word[sld_pkg::FWD_PROC_BIT] = fwd_processor[fwd_link_of(slot)];
        rd_word[sld_pkg::FWD_CHAN_HI:sld_pkg::FWD_CHAN_LO] =
          fwd_channel_end[fwd_link_of(slot)];
      end
      default: rd_word = sld_pkg::ZERO_WORD; // Unmapped index
    endcase
  end

  // Zero-wait APB: answer is ready in the first access cycle
  // Refused ones still answer, with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= sld_pkg::ZERO_WORD;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      prdata  <= (setup_ph && !pwrite) ? rd_word : sld_pkg::ZERO_WORD;
      pslverr <= setup_ph & ((grp == sld_pkg::SLD_G_NONE) | (pwrite & config_write_lock));
    end
  end

  // Debug configuration for this tile
  // Only the two enable bits exist
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_cfg_q <= 2'h0;
    end else if (wr_ok && grp == sld_pkg::SLD_G_DBGCFG) begin
      dbg_cfg_q <= {pwdata[sld_pkg::DBG_REQ_EN_BIT], pwdata[sld_pkg::DBG_DRIVE_EN_BIT]};
    end
  end

  // The shared line is a pin, so it passes two flops before use
  // Idle level at reset: no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_meta_q <= 1'b1;
      line_sync_q <= 1'b1;
      line_prev_q <= 1'b1;
    end else begin
      line_meta_q <= shared_debug_line_n_in;
      line_sync_q <= line_meta_q;
      line_prev_q <= line_sync_q;
    end
  end

  assign line_fall = line_prev_q & ~line_sync_q;

  // Open-drain drive: only ever pulls low
  // Request is a level, not an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_debug_line_n_out <= 1'b0;
      shared_debug_line_n_oe  <= 1'b0;
      core1_debug_request     <= 1'b0;
    end else begin
      shared_debug_line_n_out <= 1'b0;
      shared_debug_line_n_oe  <= dbg_cfg_q[0] & core1_in_debug_flag;
      core1_debug_request     <= dbg_cfg_q[1] & ~line_sync_q;
    end
  end

  // Latest event source; a new event wins over a software write
  // A pulling core is named, else the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_src_q <= 3'h0;
    end else if (line_fall) begin
      dbg_src_q[1] <= shared_debug_line_n_oe;
      dbg_src_q[0] <= core0_drives_debug_line;
      dbg_src_q[2] <= ~shared_debug_line_n_oe & ~core0_drives_debug_line;
    end else if (wr_ok && grp == sld_pkg::SLD_G_DBGSRC) begin
      dbg_src_q <= {pwdata[sld_pkg::SRC_PIN_BIT], pwdata[sld_pkg::SRC_CORE1_BIT],
                    pwdata[sld_pkg::SRC_CORE0_BIT]};
    end
  end

  // Direction and network of external links
  // Status bits written here are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_direction <= '0;
      link_network   <= '0;
    end else if (wr_ok && grp == sld_pkg::SLD_G_EXT) begin
      link_direction[slot] <= pwdata[sld_pkg::ST_DIR_HI:sld_pkg::ST_DIR_LO];
      link_network[slot]   <= pwdata[sld_pkg::ST_NET_HI:sld_pkg::ST_NET_LO];
    end
  end

  // Network of processor links; they carry no direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_link_network <= '0;
    end else if (wr_ok && grp == sld_pkg::SLD_G_PROC) begin
      proc_link_network[slot] <= pwdata[sld_pkg::ST_NET_HI:sld_pkg::ST_NET_LO];
    end
  end

  // Link setup fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_enable    <= '0;
      link_five_wire <= '0;
      sym_field_q    <= '0;
      tok_field_q    <= '0;
    end else if (wr_ok && grp == sld_pkg::SLD_G_SETUP) begin
      link_enable[slot]    <= pwdata[sld_pkg::CFG_EN_BIT];
      link_five_wire[slot] <= pwdata[sld_pkg::CFG_WIDE_BIT];
      sym_field_q[slot]    <= pwdata[sld_pkg::CFG_SYM_HI:sld_pkg::CFG_SYM_LO];
      tok_field_q[slot]    <= pwdata[sld_pkg::CFG_TOK_HI:sld_pkg::CFG_TOK_LO];
    end
  end

  // Idle gaps handed to the transmitter already include the plus one
  // One cycle later, but no adder on the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_symbol_gap <= '0;
      link_token_gap  <= '0;
    end else begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        link_symbol_gap[i] <= {1'b0, sym_field_q[i]} + 12'h001;
        link_token_gap[i]  <= {1'b0, tok_field_q[i]} + 12'h001;
      end
    end
  end

  // One-cycle strobes from the write-only bits
  // Self-clearing: no write of zero needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_credit_request_token    <= '0;
      link_rx_reset <= '0;
    end else begin
      link_credit_request_token    <= '0;
      link_rx_reset <= '0;
      if (wr_ok && grp == sld_pkg::SLD_G_SETUP) begin
        link_credit_request_token[slot]    <= pwdata[sld_pkg::CFG_CREDIT_REQUEST_TOKEN_BIT];
        link_rx_reset[slot] <= pwdata[sld_pkg::CFG_RXRST_BIT];
      end
    end
  end

  // Sticky receive error; cleared by a receiver reset, new error wins
  // No other way to clear it except presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= '0;
    end else begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        if (link_rx_error[i]) begin
          err_q[i] <= 1'b1;
        end else if (link_rx_reset[i]) begin
          err_q[i] <= 1'b0;
        end
      end
    end
  end

  // Static forwarding, slot reordered to link letter
  // Reserved bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_enable      <= '0;
      fwd_processor   <= '0;
      fwd_channel_end <= '0;
    end else if (wr_ok && grp == sld_pkg::SLD_G_FWD) begin
      fwd_enable[fwd_link_of(slot)]      <= pwdata[sld_pkg::FWD_EN_BIT];
      fwd_processor[fwd_link_of(slot)]   <= pwdata[sld_pkg::FWD_PROC_BIT];
      fwd_channel_end[fwd_link_of(slot)] <=
        pwdata[sld_pkg::FWD_CHAN_HI:sld_pkg::FWD_CHAN_LO];
    end
  end

endmodule

// File: tb/sld_regs_asserts.sv
`timescale 1ns/1ps
// Watches the register bank pins; only ports with a rule on them are taken
module sld_regs_asserts #(
  parameter int NUM_LINKS = 8
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [11:0]                paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       config_write_lock,
  input wire logic                       shared_debug_line_n_in,
  input wire logic                       shared_debug_line_n_out,
  input wire logic                       shared_debug_line_n_oe,
  input wire logic                       core1_in_debug_flag,
  input wire logic                       core1_debug_request,
  input wire logic [NUM_LINKS-1:0][3:0]  link_direction,
  input wire logic [NUM_LINKS-1:0][1:0]  link_network,
  input wire logic [NUM_LINKS-1:0]       link_enable,
  input wire logic [NUM_LINKS-1:0]       link_five_wire,
  input wire logic [NUM_LINKS-1:0]       link_credit_request_token,
  input wire logic [NUM_LINKS-1:0]       link_rx_reset,
  input wire logic [NUM_LINKS-1:0][11:0] link_symbol_gap,
  input wire logic [NUM_LINKS-1:0][11:0] link_token_gap,
  input wire logic [NUM_LINKS-1:0]       fwd_enable,
  input wire logic [NUM_LINKS-1:0]       fwd_processor,
  input wire logic [NUM_LINKS-1:0][4:0]  fwd_channel_end
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted write in its access cycle
  wire logic wr_ok = psel && penable && pwrite && pready && !config_write_lock;

  AST_SETUP_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  AST_REQ_IDLE: assert property (shared_debug_line_n_in [*5] |-> !core1_debug_request)
    else $error("request with idle line");
  AST_DRIVE_OFF: assert property (!core1_in_debug_flag [*2] |-> !shared_debug_line_n_oe)
    else $error("line driven without flag");
  AST_OPEN_DRAIN: assert property (shared_debug_line_n_out == 1'b0)
    else $error("line output not low");
  AST_CREDIT_REQUEST_TOKEN_CAUSE: assert property (link_credit_request_token != '0 |->
    $past(wr_ok && paddr[11:5] == 7'h10 && pwdata[24]))
    else $error("credit_request_token without write");
  AST_RXRST_PULSE: assert property (wr_ok && paddr == 12'h214 && pwdata[23] |=>
    link_rx_reset[5] ##1 !link_rx_reset[5])
    else $error("rx reset pulse wrong");
  AST_SETUP_BITS: assert property (wr_ok && paddr == 12'h200 |=>
    link_enable[0] == $past(pwdata[31]) && link_five_wire[0] == $past(pwdata[30]))
    else $error("enable or width wrong");
  AST_TOKEN_GAP: assert property (wr_ok && paddr == 12'h200 |->
    ##2 link_token_gap[0] == {1'b0, $past(pwdata[10:0], 2)} + 12'h001)
    else $error("token gap wrong");
  AST_SYM_GAP: assert property (wr_ok && paddr == 12'h21C |->
    ##2 link_symbol_gap[7] == {1'b0, $past(pwdata[21:11], 2)} + 12'h001)
    else $error("symbol gap wrong");
  AST_DIR_NET: assert property (wr_ok && paddr == 12'h080 |=>
    link_direction[0] == $past(pwdata[11:8]) && link_network[0] == $past(pwdata[5:4]))
    else $error("direction or network wrong");
  AST_FWD_SLOT: assert property (wr_ok && paddr == 12'h280 |=>
    fwd_enable[2] == $past(pwdata[31]) && fwd_processor[2] == $past(pwdata[8])
    && fwd_channel_end[2] == $past(pwdata[4:0]))
    else $error("slot zero not link C");
  AST_LOCKED: assert property (psel && penable && pwrite && config_write_lock |->
    pslverr ##1 $stable(link_enable) && $stable(fwd_enable) && $stable(link_network))
    else $error("locked write took effect");
  cover property (link_credit_request_token != 8'h00);
  cover property (core1_debug_request);
  cover property (psel && penable && pwrite && config_write_lock);
endmodule
bind sld_regs sld_regs_asserts #(.NUM_LINKS(NUM_LINKS)) i_sld_regs_asserts (.*);

// File: tb/sld_remote_model.sv
`timescale 1ns/1ps
// Far-end switch of each external link
module sld_remote_model (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       slow,
  input wire logic [7:0] link_credit_request_token,
  input wire logic [7:0] err_req,
  output logic     [7:0] link_credit_issued,
  output logic     [7:0] link_credit_held,
  output logic     [7:0] link_rx_error
);
  logic [4:0] wait_q [8];
  // Credit comes back 1 or 20 clocks after a credit_request_token, as a slow remote would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_credit_held <= 8'h00;
      link_credit_issued <= 8'h00;
      for (int i = 0; i < 8; i++) wait_q[i] <= 5'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (link_credit_request_token[i]) begin
          link_credit_held[i] <= 1'b0;
          wait_q[i] <= slow ? 5'h14 : 5'h01;
        end else if (wait_q[i] == 5'h01) begin
          link_credit_held[i] <= 1'b1;
          link_credit_issued[i] <= 1'b1;
          wait_q[i] <= 5'h00;
        end else if (wait_q[i] != 5'h00) begin
          wait_q[i] <= wait_q[i] - 5'h01;
        end
      end
    end
  end
  // Receive faults only when the bench asks for them
  assign link_rx_error = err_req;
endmodule

// File: tb/switch_link_debug_config_regs_bench.sv
`timescale 1ns/1ps
module switch_link_debug_config_regs_bench;
  logic pclk, presetn, psel, penable, pwrite, config_write_lock, pready, pslverr, pin_low, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, ex;
  logic shared_debug_line_n_in, shared_debug_line_n_out, shared_debug_line_n_oe;
  logic core1_in_debug_flag, core0_drives_debug_line, core1_debug_request;
  logic [7:0][1:0] ext_source_target_kind, proc_source_target_kind;
  logic [7:0][1:0] link_network, proc_link_network;
  logic [7:0][7:0] ext_dest_link, proc_dest_link;
  logic [7:0] ext_junk, ext_dest_busy, ext_source_busy;
  logic [7:0] proc_junk, proc_dest_busy, proc_source_busy;
  logic [7:0] link_rx_error, link_credit_issued, link_credit_held, err_req, cred;
  logic [7:0][3:0] link_direction;
  logic [7:0] link_enable, link_five_wire, link_credit_request_token, link_rx_reset, fwd_enable, fwd_processor;
  logic [7:0][11:0] link_symbol_gap, link_token_gap;
  logic [7:0][4:0] fwd_channel_end;
  logic [15:0] lfsr;
  int n_fail, check_count;

  sld_regs i_sld_regs (.*);
  sld_remote_model i_sld_remote_model (.*);
  // Open-drain debug wire: low when any party pulls it
  assign shared_debug_line_n_in = !(shared_debug_line_n_oe | pin_low | core0_drives_debug_line);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd(output logic [31:0] r);
    lfsr = step(lfsr);
    r[15:0] = lfsr;
    lfsr = step(lfsr);
    r[31:16] = lfsr;
  endtask

  function automatic logic [31:0] st(input logic [1:0] k, input logic [7:0] d,
                                     input logic [3:0] r, input logic [1:0] n, input logic [2:0] f);
    return {6'h0, k, d, 4'h0, r, 2'h0, n, 1'b0, f};
  endfunction

  // One APB transfer, held until pready; an idle cycle follows so psel drops cleanly
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d, input logic err);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    chk("pslverr", err, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Random per-link status, with every target kind present on the external links
  task automatic shuffle;
    for (int i = 0; i < 8; i++) begin
      rnd(v);
      ext_source_target_kind[i] <= 2'(i);
      ext_dest_link[i] <= v[9:2];
      {ext_junk[i], ext_dest_busy[i], ext_source_busy[i]} <= v[12:10];
      proc_source_target_kind[i] <= v[14:13];
      proc_dest_link[i] <= v[22:15];
      {proc_junk[i], proc_dest_busy[i], proc_source_busy[i]} <= v[25:23];
    end
  endtask

  // Main sequence
  initial begin
    n_fail = 0;
    check_count = 0;
    lfsr = 16'hCF13;
    {presetn, psel, penable, pwrite, paddr, pwdata, config_write_lock} <= '0;
    {core1_in_debug_flag, core0_drives_debug_line, pin_low, slow, err_req, cred} <= '0;
    shuffle();
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 10'h080 + 10'(i), 0, 1'b0);
      chk("setup_rst", 32'h0, rd);
      apb(1'b0, 10'h0A0 + 10'(i), 0, 1'b0);
      chk("fwd_rst", 32'h0, rd);
    end
    apb(1'b0, 10'h011, 0, 1'b0);
    chk("dbgcfg_rst", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      rnd(v);
      apb(1'b1, 10'h020 + 10'(i), v, 1'b0);
      apb(1'b0, 10'h020 + 10'(i), 0, 1'b0);
      ex = st(ext_source_target_kind[i], ext_dest_link[i], v[11:8], v[5:4],
              {ext_junk[i], ext_dest_busy[i], ext_source_busy[i]});
      chk("ext_status", ex, rd);
      chk("dir_net", {v[11:8], v[5:4]}, {link_direction[i], link_network[i]});
      apb(1'b1, 10'h040 + 10'(i), v, 1'b0);
      apb(1'b0, 10'h040 + 10'(i), 0, 1'b0);
      ex = st(proc_source_target_kind[i], proc_dest_link[i], 4'h0, v[5:4],
              {proc_junk[i], proc_dest_busy[i], proc_source_busy[i]});
      chk("proc_status", ex, rd);
      chk("proc_net", v[5:4], proc_link_network[i]);
      rnd(v);
      cred[i] = cred[i] | v[24];
      apb(1'b1, 10'h080 + 10'(i), v, 1'b0);
      @(posedge pclk);
      chk("gaps", {{1'b0, v[21:11]} + 12'h001, {1'b0, v[10:0]} + 12'h001},
          {link_symbol_gap[i], link_token_gap[i]});
      chk("en_wide", v[31:30], {link_enable[i], link_five_wire[i]});
      apb(1'b0, 10'h080 + 10'(i), 0, 1'b0);
      chk("setup", {v[31:30], 3'h0, cred[i], cred[i], 3'h0, v[21:0]}, rd);
      rnd(v);
      apb(1'b1, 10'h0A0 + 10'(i), v, 1'b0);
      apb(1'b0, 10'h0A0 + 10'(i), 0, 1'b0);
      chk("fwd_reg", v & 32'h8000_011F, rd);
      chk("fwd_out", {v[31], v[8], v[4:0]},
          {fwd_enable[i ^ 2], fwd_processor[i ^ 2], fwd_channel_end[i ^ 2]});
    end
    // Slow remote: credit is gone right after credit_request_token and returns later
    slow <= 1'b1;
    apb(1'b1, 10'h083, 32'h0100_0000, 1'b0);
    apb(1'b0, 10'h083, 0, 1'b0);
    chk("held_clear", 1'b0, rd[25]);
    for (int k = 0; k < 20 && rd[25] !== 1'b1; k++) apb(1'b0, 10'h083, 0, 1'b0);
    chk("held_back", 1'b1, rd[25]);
    // Receive fault sets the error flag; a receiver reset clears it
    err_req <= 8'h20;
    @(posedge pclk);
    err_req <= 8'h00;
    apb(1'b0, 10'h085, 0, 1'b0);
    chk("rx_err", 1'b1, rd[27]);
    apb(1'b1, 10'h085, 32'h0080_0000, 1'b0);
    apb(1'b0, 10'h085, 0, 1'b0);
    chk("rx_err_clr", 1'b0, rd[27]);
    // Locked writes are refused; unmapped places answer with an error
    apb(1'b0, 10'h0A0, 0, 1'b0);
    ex = rd;
    config_write_lock <= 1'b1;
    apb(1'b1, 10'h0A0, ~ex, 1'b1);
    apb(1'b1, 10'h080, 32'hFFFF_FFFF, 1'b1);
    config_write_lock <= 1'b0;
    apb(1'b0, 10'h0A0, 0, 1'b0);
    chk("locked", ex, rd);
    apb(1'b0, 10'h012, 0, 1'b1);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, 10'h028, ex, 1'b1);
    // Debug line: pin, tile-1 core and tile-0 core as event sources
    apb(1'b1, 10'h011, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, 10'h011, 0, 1'b0);
    chk("dbgcfg", 32'h3, rd);
    apb(1'b1, 10'h01F, 0, 1'b0);
    pin_low <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("request", 1'b1, core1_debug_request);
    pin_low <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, 10'h01F, 0, 1'b0);
    chk("src_pin", 32'h10, rd);
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, 10'h01F, 0, 1'b0);
      core1_in_debug_flag <= (c == 0);
      core0_drives_debug_line <= (c == 1);
      repeat (8) @(posedge pclk);
      chk("oe", c == 0, shared_debug_line_n_oe);
      core1_in_debug_flag <= 1'b0;
      core0_drives_debug_line <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, 10'h01F, 0, 1'b0);
      chk("src_core", (c == 0) ? 32'h2 : 32'h1, rd);
    end
    apb(1'b1, 10'h011, 0, 1'b0);
    pin_low <= 1'b1;
    core1_in_debug_flag <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("req_off", 1'b0, core1_debug_request);
    chk("oe_off", 1'b0, shared_debug_line_n_oe);
    end_sim();
  end
endmodule
